// *** pkg/pep_pkg.sv ***
// Package: register map, field layout, reset values and encodings of the port parity block
//
// Contract
// - While check_disable (control bit 0) is set no parity check is made and no parity error is ever flagged.
// - While bad_parity_inject (control bit 1) is set every word of a qualifying packet goes out with inverted parity.
//   The code keeps one match decision for both sources, so interleaved packets follow the latest header.
// - A packet qualifies only when header byte zero bits 7:0 equal the match length in control bits 15:8.
// - Injection covers both packets taken from the ingress link and packets the port originates itself.
// - A detected parity error sets parity_error_flag (status bit 0), which holds until software writes one to it.
// - A report is sent only when the status flag rises from zero to one, in the form chosen by reporting bits 1:0.
// - Reporting code 0x0 sends nothing, 0x1 sends ERR_COR, 0x2 sends ERR_NONFATAL, 0x3 sends ERR_FATAL.
// - After reset the reporting field holds 0x2 and check_disable, bad_parity_inject and match length are zero.
package pep_pkg;

    // ---------------------------------------------------------------
    // Register offsets (byte addresses)
    // ---------------------------------------------------------------
    localparam logic [11:0] PARITY_ERROR_CONTROL_OFFSET = 12'h740;
    localparam logic [11:0] PARITY_ERROR_STATUS_OFFSET = 12'h744;
    localparam logic [11:0] PARITY_ERROR_REPORTING_OFFSET = 12'h748;
    localparam logic [11:0] PARITY_IRQ_MASK_OFFSET = 12'h760;

    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int CHECK_DISABLE_BIT = 0;
    localparam int BAD_PARITY_INJECT_BIT = 1;
    localparam int MATCH_LENGTH_LSB = 8;
    localparam int MATCH_LENGTH_MSB = 15;
    localparam int PARITY_ERROR_FLAG_BIT = 0;
    localparam int REPORT_LSB = 0;
    localparam int REPORT_MSB = 1;

    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
    localparam logic [1:0] REPORT_RESET = 2'h2;
    localparam logic IRQ_MASK_RESET = 1'h0;
    localparam logic [31:0] UNMAPPED_READ_VALUE = 32'h0000_0000;

    // ---------------------------------------------------------------
    // Report encodings
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        REPORT_NONE = 2'h0,
        REPORT_COR = 2'h1,
        REPORT_NONFATAL = 2'h2,
        REPORT_FATAL = 2'h3
    } pep_report_type;

endpackage : pep_pkg

// *** rtl/pep_parity_chk.sv ***
// Parity check of words arriving from the switch core
`timescale 1ns/1ps
`default_nettype none
module pep_parity_chk #(
    parameter int DATA_W = 32
) (
    input wire logic [DATA_W-1:0] data,
    input wire logic parity,
    input wire logic valid,
    input wire logic disable_check,
    output logic error
);
    always_comb begin
        error = valid && !disable_check && ((^data) != parity);
    end
endmodule : pep_parity_chk
`default_nettype wire

// *** rtl/pep_parity_gen.sv ***
// Parity generation and optional corruption for words sent to the switch core
`timescale 1ns/1ps
`default_nettype none
module pep_parity_gen #(
    parameter int DATA_W = 32
) (
    input wire logic [DATA_W-1:0] data,
    input wire logic corrupt,
    output logic parity
);
    // Even parity; injection simply flips it so the core sees a mismatch
    always_comb begin
        parity = (^data) ^ corrupt;
    end
endmodule : pep_parity_gen
`default_nettype wire

// *** rtl/pep_port_parity.sv ***
// Per-port end-to-end parity: check, generation, injection, status, reporting and registers
//
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module pep_port_parity #(
    parameter int DATA_W = 32
) (
    input wire logic ref_clk,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [11:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [1:0] avs_response,
    // Data arriving from the switch core
    input wire logic [DATA_W-1:0] core_rx_data,
    input wire logic core_rx_parity,
    input wire logic core_rx_valid,
    // Packets from the ingress link toward the core
    input wire logic [DATA_W-1:0] link_tx_data,
    input wire logic link_tx_valid,
    input wire logic link_tx_sop,
    // Packets originated by the port toward the core
    input wire logic [DATA_W-1:0] own_tx_data,
    input wire logic own_tx_valid,
    input wire logic own_tx_sop,
    output logic own_tx_ready,
    // Toward the switch core
    output logic [DATA_W-1:0] core_tx_data,
    output logic core_tx_parity,
    output logic core_tx_valid,
    // Error message request to the root
    output logic err_msg_valid,
    output logic [1:0] err_msg_kind,
    output logic irq
);

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    logic check_disable_reg, check_disable_next;
    logic bad_parity_inject_reg, bad_parity_inject_next;
    logic [7:0] match_length_reg, match_length_next;
    logic parity_error_flag_reg, parity_error_flag_next;
    logic [1:0] report_reg, report_next;
    logic irq_mask_reg, irq_mask_next;
    logic [31:0] avs_readdata_reg, avs_readdata_next;
    logic ack_reg, ack_next;
    logic [1:0] resp_reg, resp_next;
    logic err_msg_valid_reg, err_msg_valid_next;
    logic [1:0] err_msg_kind_reg, err_msg_kind_next;
    logic [DATA_W-1:0] core_tx_data_reg, core_tx_data_next;
    logic core_tx_parity_reg, core_tx_parity_next;
    logic core_tx_valid_reg, core_tx_valid_next;
    logic pkt_match_reg, pkt_match_next;

    logic parity_error;
    logic gen_parity;
    logic sel_valid, sel_sop, corrupt_word, word_match;
    logic [DATA_W-1:0] sel_data;
    logic wr_ctl, wr_sts, wr_rep, wr_msk, access;

    // ---------------------------------------------------------------
    // Check of core data
    // ---------------------------------------------------------------
    pep_parity_chk #(.DATA_W(DATA_W)) u_chk (
        .data(core_rx_data),
        .parity(core_rx_parity),
        .valid(core_rx_valid),
        .disable_check(check_disable_reg),
        .error(parity_error)
    );

    // ---------------------------------------------------------------
    // Transmit path: link traffic has priority, own packets wait
    // ---------------------------------------------------------------
    // Arbitration is per word: a link word always wins, so an own packet
    // interleaved with link traffic shares the stored match decision.
    always_comb begin
        own_tx_ready = !link_tx_valid;
        sel_valid = link_tx_valid || own_tx_valid;
        sel_data = link_tx_valid ? link_tx_data : own_tx_data;
        sel_sop = link_tx_valid ? link_tx_sop : own_tx_sop;
    end

    always_comb begin
        word_match = (sel_data[7:0] == match_length_reg);
        pkt_match_next = pkt_match_reg;
        if (sel_valid && sel_sop) begin
            pkt_match_next = word_match;
        end
        // Header word decides; later words follow the stored decision
        corrupt_word = bad_parity_inject_reg && (sel_sop ? word_match : pkt_match_reg);
    end

    pep_parity_gen #(.DATA_W(DATA_W)) u_gen (
        .data(sel_data),
        .corrupt(corrupt_word),
        .parity(gen_parity)
    );

    always_comb begin
        core_tx_valid_next = sel_valid;
        core_tx_data_next = sel_valid ? sel_data : core_tx_data_reg;
        core_tx_parity_next = sel_valid ? gen_parity : core_tx_parity_reg;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            core_tx_valid_reg <= 1'b0;
            core_tx_data_reg <= '0;
            core_tx_parity_reg <= 1'b0;
            pkt_match_reg <= 1'b0;
        end else begin
            core_tx_valid_reg <= core_tx_valid_next;
            core_tx_data_reg <= core_tx_data_next;
            core_tx_parity_reg <= core_tx_parity_next;
            pkt_match_reg <= pkt_match_next;
        end
    end

    // ---------------------------------------------------------------
    // Register bus
    // ---------------------------------------------------------------
    // Every access answers one cycle after it is presented
    always_comb begin
        access = (avs_read || avs_write) && !ack_reg;
        // Writes land only at the edge where waitrequest is low, as the master expects
        wr_ctl = avs_write && ack_reg && avs_address == pep_pkg::PARITY_ERROR_CONTROL_OFFSET;
        wr_sts = avs_write && ack_reg && avs_address == pep_pkg::PARITY_ERROR_STATUS_OFFSET;
        wr_rep = avs_write && ack_reg && avs_address == pep_pkg::PARITY_ERROR_REPORTING_OFFSET;
        wr_msk = avs_write && ack_reg && avs_address == pep_pkg::PARITY_IRQ_MASK_OFFSET;
        ack_next = access;
        resp_next = 2'h0;
        avs_readdata_next = pep_pkg::UNMAPPED_READ_VALUE;
        if (access) begin
            unique case (avs_address)
                pep_pkg::PARITY_ERROR_CONTROL_OFFSET: begin
                    avs_readdata_next[pep_pkg::CHECK_DISABLE_BIT] = check_disable_reg;
                    avs_readdata_next[pep_pkg::BAD_PARITY_INJECT_BIT] = bad_parity_inject_reg;
                    avs_readdata_next[pep_pkg::MATCH_LENGTH_MSB:pep_pkg::MATCH_LENGTH_LSB] = match_length_reg;
                end
                pep_pkg::PARITY_ERROR_STATUS_OFFSET: begin
                    avs_readdata_next[pep_pkg::PARITY_ERROR_FLAG_BIT] = parity_error_flag_reg;
                end
                pep_pkg::PARITY_ERROR_REPORTING_OFFSET: begin
                    avs_readdata_next[pep_pkg::REPORT_MSB:pep_pkg::REPORT_LSB] = report_reg;
                end
                pep_pkg::PARITY_IRQ_MASK_OFFSET: begin
                    avs_readdata_next[0] = irq_mask_reg;
                end
                default: begin
                    resp_next = 2'h2;
                end
            endcase
            if (avs_write) begin
                avs_readdata_next = pep_pkg::UNMAPPED_READ_VALUE;
            end
        end
    end

    always_comb begin
        check_disable_next = check_disable_reg;
        bad_parity_inject_next = bad_parity_inject_reg;
        match_length_next = match_length_reg;
        report_next = report_reg;
        irq_mask_next = irq_mask_reg;
        // Only documented fields are stored; reserved bits are dropped
        if (wr_ctl && avs_byteenable[0]) begin
            check_disable_next = avs_writedata[pep_pkg::CHECK_DISABLE_BIT];
            bad_parity_inject_next = avs_writedata[pep_pkg::BAD_PARITY_INJECT_BIT];
        end
        if (wr_ctl && avs_byteenable[1]) begin
            match_length_next = avs_writedata[pep_pkg::MATCH_LENGTH_MSB:pep_pkg::MATCH_LENGTH_LSB];
        end
        if (wr_rep && avs_byteenable[0]) begin
            report_next = avs_writedata[pep_pkg::REPORT_MSB:pep_pkg::REPORT_LSB];
        end
        if (wr_msk && avs_byteenable[0]) begin
            irq_mask_next = avs_writedata[0];
        end
    end

    // ---------------------------------------------------------------
    // Status flag and reporting
    // ---------------------------------------------------------------
    always_comb begin
        parity_error_flag_next = parity_error_flag_reg;
        if (wr_sts && avs_byteenable[0] && avs_writedata[pep_pkg::PARITY_ERROR_FLAG_BIT]) begin
            parity_error_flag_next = 1'b0;
        end
        // A new error in the clearing cycle wins over the clear
        if (parity_error) begin
            parity_error_flag_next = 1'b1;
        end
        // Message only on the rising edge of the flag
        err_msg_valid_next = parity_error && !parity_error_flag_reg
            && report_reg != pep_pkg::REPORT_NONE;
        err_msg_kind_next = err_msg_valid_next ? report_reg : err_msg_kind_reg;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            check_disable_reg <= 1'b0;
            bad_parity_inject_reg <= 1'b0;
            match_length_reg <= 8'h00;
            report_reg <= pep_pkg::REPORT_RESET;
            irq_mask_reg <= pep_pkg::IRQ_MASK_RESET;
            parity_error_flag_reg <= 1'b0;
            err_msg_valid_reg <= 1'b0;
            err_msg_kind_reg <= 2'h0;
            avs_readdata_reg <= 32'h0000_0000;
            ack_reg <= 1'b0;
            resp_reg <= 2'h0;
        end else begin
            check_disable_reg <= check_disable_next;
            bad_parity_inject_reg <= bad_parity_inject_next;
            match_length_reg <= match_length_next;
            report_reg <= report_next;
            irq_mask_reg <= irq_mask_next;
            parity_error_flag_reg <= parity_error_flag_next;
            err_msg_valid_reg <= err_msg_valid_next;
            err_msg_kind_reg <= err_msg_kind_next;
            avs_readdata_reg <= avs_readdata_next;
            ack_reg <= ack_next;
            resp_reg <= resp_next;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    always_comb begin
        avs_waitrequest = (avs_read || avs_write) && !ack_reg;
        avs_readdata = avs_readdata_reg;
        avs_response = resp_reg;
        core_tx_data = core_tx_data_reg;
        core_tx_parity = core_tx_parity_reg;
        core_tx_valid = core_tx_valid_reg;
        err_msg_valid = err_msg_valid_reg;
        err_msg_kind = err_msg_kind_reg;
        irq = parity_error_flag_reg && irq_mask_reg;
    end

endmodule : pep_port_parity
`default_nettype wire

// *** sim/pep_core_model.sv ***
// Switch core stand-in: sends words to the port and counts corrupted words from it
`timescale 1ns/1ps
`default_nettype none
module pep_core_model #(
    parameter int DATA_W = 32
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [DATA_W-1:0] core_tx_data,
    input wire logic core_tx_parity,
    input wire logic core_tx_valid,
    output logic [DATA_W-1:0] core_rx_data = '0,
    output logic core_rx_parity = 1'b0,
    output logic core_rx_valid = 1'b0
);
    int bad_tx_cnt = 0;
    always @(posedge ref_clk) begin
        if (rst) begin
            bad_tx_cnt <= 0;
        end else if (core_tx_valid === 1'b1 && core_tx_parity !== ^core_tx_data) begin
            bad_tx_cnt <= bad_tx_cnt + 1;
        end
    end
    task automatic send_word(input logic [DATA_W-1:0] d, input logic bad);
        core_rx_valid <= 1'b1;
        core_rx_data <= d;
        core_rx_parity <= (^d) ^ bad;
        @(posedge ref_clk);
        core_rx_valid <= 1'b0;
        // Released lines show the inverse so a stale word is never mistaken for a live one
        core_rx_data <= ~d;
        core_rx_parity <= ~((^d) ^ bad);
        @(posedge ref_clk);
    endtask : send_word
endmodule : pep_core_model
`default_nettype wire

// *** sim/pep_port_parity_checker.sv ***
// Concurrent checks on the ports of the port parity block
`timescale 1ns/1ps
`default_nettype none
module pep_port_parity_checker #(
    parameter int DATA_W = 32
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [11:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [DATA_W-1:0] core_rx_data,
    input wire logic core_rx_parity,
    input wire logic core_rx_valid,
    input wire logic [DATA_W-1:0] link_tx_data,
    input wire logic link_tx_valid,
    input wire logic [DATA_W-1:0] own_tx_data,
    input wire logic own_tx_valid,
    input wire logic own_tx_ready,
    input wire logic [DATA_W-1:0] core_tx_data,
    input wire logic core_tx_parity,
    input wire logic core_tx_valid,
    input wire logic err_msg_valid,
    input wire logic [1:0] err_msg_kind
);
    // ----
    // Shadow fields; they load at the same edge as the design, a cycle ahead of the outputs they gate, so traffic must not overlap a write
    // ----
    logic [1:0] ctl_reg;
    logic [1:0] rep_reg;
    logic rx_bad_reg;
    logic wr_done;
    assign wr_done = avs_write && !avs_waitrequest && avs_byteenable[0];
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctl_reg <= 2'h0;
            rep_reg <= pep_pkg::REPORT_RESET;
            rx_bad_reg <= 1'b0;
        end else begin
            if (wr_done && avs_address == pep_pkg::PARITY_ERROR_CONTROL_OFFSET) begin
                ctl_reg <= avs_writedata[1:0];
            end
            if (wr_done && avs_address == pep_pkg::PARITY_ERROR_REPORTING_OFFSET) begin
                rep_reg <= avs_writedata[1:0];
            end
            rx_bad_reg <= core_rx_valid && (core_rx_parity != ^core_rx_data);
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence s_msg_once;
        err_msg_valid ##1 !err_msg_valid;
    endsequence
    property p_wait; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
    property p_link; link_tx_valid |=> core_tx_valid && core_tx_data == $past(link_tx_data); endproperty
    property p_own; own_tx_valid && !link_tx_valid |=> core_tx_valid && core_tx_data == $past(own_tx_data); endproperty
    property p_gen; core_tx_valid && !ctl_reg[1] |-> core_tx_parity == ^core_tx_data; endproperty
    property p_ready; link_tx_valid |-> !own_tx_ready; endproperty
    property p_cause; err_msg_valid |-> rx_bad_reg && !ctl_reg[0]; endproperty
    property p_pulse; err_msg_valid |-> s_msg_once; endproperty
    property p_kind; err_msg_valid |-> err_msg_kind == rep_reg && rep_reg != 2'h0; endproperty
    property p_resv;
        avs_read && !avs_waitrequest && avs_address == pep_pkg::PARITY_ERROR_STATUS_OFFSET |-> avs_readdata[31:1] == 31'h0;
    endproperty
    a_wait: assert property (p_wait) else $error("bus answer took more than one cycle");
    a_link: assert property (p_link) else $error("ingress word not forwarded next cycle");
    a_own: assert property (p_own) else $error("own word not forwarded next cycle");
    a_gen: assert property (p_gen) else $error("wrong parity without injection");
    a_ready: assert property (p_ready) else $error("own word accepted while link word present");
    a_cause: assert property (p_cause) else $error("report without a checked parity error");
    a_pulse: assert property (p_pulse) else $error("report longer than one cycle");
    a_kind: assert property (p_kind) else $error("report kind differs from reporting field");
    a_resv: assert property (p_resv) else $error("reserved status bits not zero");
endmodule : pep_port_parity_checker
bind pep_port_parity pep_port_parity_checker #(.DATA_W(DATA_W)) u_checker (.ref_clk(ref_clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .core_rx_data(core_rx_data), .core_rx_parity(core_rx_parity), .core_rx_valid(core_rx_valid),
    .link_tx_data(link_tx_data), .link_tx_valid(link_tx_valid), .own_tx_data(own_tx_data),
    .own_tx_valid(own_tx_valid), .own_tx_ready(own_tx_ready),
    .core_tx_data(core_tx_data), .core_tx_parity(core_tx_parity),
    .core_tx_valid(core_tx_valid), .err_msg_valid(err_msg_valid), .err_msg_kind(err_msg_kind));
`default_nettype wire

// *** sim/tb_top.sv ***
// Self-checking bench of the port parity block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin mismatches++; $display("[ERR] t=%0t got=%h exp=%h", $time, a, e); end end
module tb_top;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] avs_address = 12'h0;
    logic avs_read = 1'b0, avs_write = 1'b0, link_tx_valid = 1'b0, link_tx_sop = 1'b0;
    logic own_tx_valid = 1'b0, own_tx_sop = 1'b0;
    logic [31:0] avs_writedata = 32'h0, link_tx_data = 32'h0, own_tx_data = 32'h0;
    logic [3:0] avs_byteenable = 4'h0;
    logic [31:0] avs_readdata, core_rx_data, core_tx_data, rd;
    logic [1:0] avs_response, err_msg_kind, rs, last_kind;
    logic avs_waitrequest, core_rx_parity, core_rx_valid, core_tx_parity, core_tx_valid, err_msg_valid, irq;
    int mismatches = 0, check_count = 0, msg_cnt = 0, cycles = 0, n, k;
    pep_port_parity #(.DATA_W(32)) uut (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
        .core_rx_data(core_rx_data), .core_rx_parity(core_rx_parity), .core_rx_valid(core_rx_valid),
        .link_tx_data(link_tx_data), .link_tx_valid(link_tx_valid), .link_tx_sop(link_tx_sop),
        .own_tx_data(own_tx_data), .own_tx_valid(own_tx_valid), .own_tx_sop(own_tx_sop), .own_tx_ready(),
        .core_tx_data(core_tx_data), .core_tx_parity(core_tx_parity), .core_tx_valid(core_tx_valid),
        .err_msg_valid(err_msg_valid), .err_msg_kind(err_msg_kind), .irq(irq));
    pep_core_model #(.DATA_W(32)) u_core (.ref_clk(ref_clk), .rst(rst), .core_tx_data(core_tx_data),
        .core_tx_parity(core_tx_parity), .core_tx_valid(core_tx_valid), .core_rx_data(core_rx_data),
        .core_rx_parity(core_rx_parity), .core_rx_valid(core_rx_valid));
    always #5 ref_clk = ~ref_clk;
    // Report pulses last one cycle, so they are caught where settled
    always @(negedge ref_clk) begin
        if (err_msg_valid === 1'b1) begin
            msg_cnt++;
            last_kind = err_msg_kind;
        end
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            print_verdict();
        end
    end
    // ----
    // Bus and stream tasks
    // ----
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] d,
                       output logic [1:0] r);
        avs_address <= a;
        avs_read <= !wr;
        avs_write <= wr;
        avs_writedata <= wd;
        avs_byteenable <= 4'hf;
        // Request stands until waitrequest is seen low at a rising edge; the answer is taken there
        do begin
            @(posedge ref_clk);
        end while (avs_waitrequest !== 1'b0 && cycles < 2990);
        d = avs_readdata;
        r = avs_response;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge ref_clk);
    endtask : bus
    task automatic wr(input logic [11:0] a, input logic [31:0] wd);
        bus(1'b1, a, wd, rd, rs);
    endtask : wr
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, rd, rs);
        `CHK(rd, e)
    endtask : rd_chk
    task automatic send_pkt(input logic lnk, input logic [31:0] hdr, input int len);
        for (int i = 0; i < len; i++) begin
            link_tx_valid <= lnk;
            own_tx_valid <= !lnk;
            link_tx_sop <= lnk && i == 0;
            own_tx_sop <= !lnk && i == 0;
            link_tx_data <= (i == 0) ? hdr : 32'hc0de_0000 + 32'(i);
            own_tx_data <= (i == 0) ? hdr : 32'hc0de_0000 + 32'(i);
            @(posedge ref_clk);
        end
        link_tx_valid <= 1'b0;
        own_tx_valid <= 1'b0;
        link_tx_data <= ~link_tx_data;
        own_tx_data <= ~own_tx_data;
        @(posedge ref_clk);
    endtask : send_pkt
    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : print_verdict
    initial begin
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        rd_chk(pep_pkg::PARITY_ERROR_CONTROL_OFFSET, 32'h0);
        `CHK(rs, 2'h0)
        rd_chk(pep_pkg::PARITY_ERROR_STATUS_OFFSET, 32'h0);
        rd_chk(pep_pkg::PARITY_ERROR_REPORTING_OFFSET, 32'h2);
        bus(1'b0, 12'h7fc, 32'h0, rd, rs);
        `CHK(rs, 2'h2)
        wr(12'h740, 32'hffff_ffff);
        rd_chk(12'h740, 32'h0000_ff03);
        wr(12'h748, 32'hffff_ffff);
        rd_chk(12'h748, 32'h3);
        wr(12'h740, 32'h0);
        wr(pep_pkg::PARITY_IRQ_MASK_OFFSET, 32'h1);
        for (k = 0; k < 4; k++) begin
            wr(12'h748, 32'(k));
            n = msg_cnt + (k != 0);
            u_core.send_word(32'h0f0f_0001 + 32'(k), 1'b1);
            `CHK(msg_cnt, n)
            if (k != 0) `CHK(last_kind, 2'(k))
            `CHK(irq, 1'b1)
            u_core.send_word(32'h1, 1'b1);
            `CHK(msg_cnt, n)
            rd_chk(12'h744, 32'h1);
            wr(12'h744, 32'hffff_ffff);
            rd_chk(12'h744, 32'h0);
            `CHK(irq, 1'b0)
        end
        wr(12'h740, 32'h1);
        n = msg_cnt;
        u_core.send_word(32'h3, 1'b1);
        rd_chk(12'h744, 32'h0);
        `CHK(msg_cnt, n)
        wr(12'h740, 32'h0000_0502);
        n = u_core.bad_tx_cnt;
        send_pkt(1'b1, 32'h0000_ab05, 3);
        send_pkt(1'b0, 32'h0000_ab05, 3);
        send_pkt(1'b1, 32'h0000_ab06, 3);
        @(posedge ref_clk);
        `CHK(u_core.bad_tx_cnt - n, 6)
        wr(12'h740, 32'h0000_0500);
        send_pkt(1'b1, 32'h0000_ab05, 2);
        @(posedge ref_clk);
        `CHK(u_core.bad_tx_cnt - n, 6)
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
